// ==== rtl/mod_handoff.sv ====
/*
  Modulation unit side of the sample handoff, clocked on the falling edge
  of the phase detector clock. A toggle request carries a staged sample and
  magnitude offset that stay stable until the acknowledge toggle returns.
*/
`timescale 1ns/1ns
module mod_handoff
  import synth_pkg::*;
(
  // Phase detector clock and core reset.
  input wire logic phase_detector_clock,
  input wire logic rst,
  // Staged sample from the core domain.
  input wire logic [DATA_W-1:0] stage_sample,
  input wire logic [MOD_M_W-1:0] stage_shift,
  input wire logic req_tgl,
  // Acknowledge toggle back to the core domain.
  output logic ack_tgl,
  // Scaled sample to the modulation unit.
  output logic [MOD_OUT_W-1:0] mod_word,
  output logic mod_word_valid
);

  logic rst_meta_ff;
  logic pd_rst_ff;
  logic req_meta_ff;
  logic req_sync_ff;
  logic req_prev_ff;
  logic signed [MOD_OUT_W-1:0] ext_sample;
  logic new_req;

  // Reset is brought into this domain through two flops.
  always_ff @(negedge phase_detector_clock) begin
    rst_meta_ff <= rst;
    pd_rst_ff <= rst_meta_ff;
  end

  // Request toggle synchronizer and edge memory.
  always_ff @(negedge phase_detector_clock) begin
    if (pd_rst_ff) begin
      req_meta_ff <= 1'b0;
      req_sync_ff <= 1'b0;
      req_prev_ff <= 1'b0;
    end else begin
      req_meta_ff <= req_tgl;
      req_sync_ff <= req_meta_ff;
      req_prev_ff <= req_sync_ff;
    end
  end

  assign new_req = req_sync_ff ^ req_prev_ff;
  assign ext_sample = MOD_OUT_W'($signed(stage_sample));

  // Sample taken on a falling edge, scaled by two to the power m.
  always_ff @(negedge phase_detector_clock) begin
    if (pd_rst_ff) begin
      mod_word <= '0;
      mod_word_valid <= 1'b0;
      ack_tgl <= 1'b0;
    end else begin
      mod_word_valid <= new_req;
      ack_tgl <= req_sync_ff;
      if (new_req) begin
        mod_word <= ext_sample <<< stage_shift;
      end
    end
  end

  property p_scaled_word;
    @(negedge phase_detector_clock) disable iff (pd_rst_ff)
      new_req |=> mod_word_valid && mod_word == ($past(ext_sample) <<< $past(stage_shift));
  endproperty
  a_scaled_word: assert property (p_scaled_word) else $error("scaled sample wrong");

  property p_valid_once;
    @(negedge phase_detector_clock) disable iff (pd_rst_ff)
      mod_word_valid |-> $past(new_req);
  endproperty
  a_valid_once: assert property (p_valid_once) else $error("spurious handoff strobe");

endmodule

// ==== rtl/pin_sync.sv ====
/*
  Two-flop synchronizer for a group of independent level inputs.
  Assumes each bit is a separate level; no word coherence is offered.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Asynchronous levels in, synchronized levels out.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // The first stage is read by the second stage only; reset takes the idle level.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule

// ==== rtl/synth_pkg.sv ====
/*
  Shared constants of the synthesizer serial register bank: register
  addresses, reset values, field positions and transfer lengths.
  Assumes it is compiled before every design file that imports it.
*/
package synth_pkg;

  // Word layout of a serial transfer.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 12;
  localparam int WORD_W = ADDR_W + DATA_W;
  localparam int CNT_W = 5;

  // Register addresses.
  localparam logic [ADDR_W-1:0] ADDR_INT_DIV = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_FRAC_HI = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_FRAC_LO = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_REF_DIV = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_PUMP = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_PD_MUX = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_MOD_CTL = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_MOD_SMP = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_DSM = 4'hE;

  // Reset values.
  localparam logic [DATA_W-1:0] RST_INT_DIV = 12'h006;
  localparam logic [DATA_W-1:0] RST_ZERO = 12'h000;

  // Field widths of the divide ratio.
  localparam int DIV_IDX_W = 9;
  localparam int FRAC_HI_W = 10;
  localparam int FRAC_LO_W = 8;
  localparam int FRAC_W = FRAC_HI_W + FRAC_LO_W;
  localparam int REF_IDX_W = 5;

  // Power down and output select register fields.
  localparam int PDM_FULL_PD_BIT = 0;
  localparam int PDM_SYN_PD_BIT = 1;
  localparam int PDM_INT_MODE_BIT = 2;
  localparam int PDM_FRAC10_BIT = 3;
  localparam int PDM_MUX_LSB = 6;
  localparam int PDM_MUX_W = 3;
  localparam int PDM_MUX_TRI_BIT = 9;

  // Modulation control register fields.
  localparam int MOD_M_LSB = 0;
  localparam int MOD_M_W = 4;
  localparam int MOD_ADDR_DIS_BIT = 4;
  localparam int MOD_PIN_SEL_BIT = 5;

  // Transfer lengths in serial clocks.
  localparam logic [CNT_W-1:0] SHORT_MIN = 5'h02;
  localparam logic [CNT_W-1:0] SHORT_MAX = 5'h0C;
  localparam logic [CNT_W-1:0] FULL_LEN = 5'h10;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;

  // Width of a scaled sample handed to the modulation unit.
  localparam int MOD_OUT_W = DATA_W + (1 << MOD_M_W) - 1;

  // Sign-extends the low n bits of a sample to the full register width.
  function automatic logic [DATA_W-1:0] sext_sample(input logic [DATA_W-1:0] val,
                                                     input logic [CNT_W-1:0] n);
    logic [DATA_W-1:0] res;
    res = val;
    for (int i = 1; i < DATA_W; i++) begin
      if (i >= int'(n)) begin
        res[i] = res[i-1];
      end
    end
    return res;
  endfunction

endpackage

// ==== rtl/synth_serial_register_bank.sv ====
/*
  Write-only register bank of a fractional-N synthesizer with its three-wire
  serial load logic and the modulation sample path.
  Assumes core_clk is the reference oscillator clock and runs at least four
  times faster than the serial clock; all pins are asynchronous to it.
*/
`timescale 1ns/1ns

module synth_serial_register_bank
  import synth_pkg::*;
(
  // Core clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Modulation unit clock.
  input wire logic phase_detector_clock,
  // Serial pins.
  input wire logic sclk,
  input wire logic sdata,
  input wire logic cs_n,
  input wire logic mod_in,
  // Applied divide ratio.
  output logic [DIV_IDX_W-1:0] divider_index,
  output logic [FRAC_W-1:0] dividend,
  output logic ratio_update,
  output logic integer_mode,
  output logic fraction_10bit,
  // Other configuration.
  output logic [REF_IDX_W:0] ref_divide_ratio,
  output logic [DATA_W-1:0] pump_gain_control,
  output logic [DATA_W-1:0] powerdown_output_select,
  output logic [DATA_W-1:0] modulator_control,
  // Modulation unit.
  output logic [MOD_OUT_W-1:0] mod_word,
  output logic mod_word_valid
);

  typedef enum logic {SER_IDLE, SER_SHIFT} ser_state_e;
  ser_state_e state_ff;
  logic [3:0] pins_s;
  logic cs_n_s, sclk_s, sdata_s, mod_in_s;
  logic sclk_prev_ff, cs_n_prev_ff, sclk_rise, cs_start, cs_end, end_ev;
  logic [WORD_W-1:0] shift_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic is_full, is_short, wr_en, short_ld;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] mod_shift_ff, wr_data, short_sample;
  logic [DATA_W-1:0] int_div_ff, frac_hi_ff, frac_lo_ff, ref_div_ff, pump_ff;
  logic [DATA_W-1:0] pd_mux_ff, mod_ctl_ff, mod_smp_ff, dsm_ff, stage_ff;
  logic mod_load_ff, update_ff, req_tgl_ff, pend_ff, ack_tgl, ack_s, busy;
  logic [DIV_IDX_W-1:0] div_applied_ff;
  logic [FRAC_W-1:0] frac_applied_ff;
  logic [REF_IDX_W:0] ref_ratio_ff;
  logic [MOD_M_W-1:0] stage_m_ff;

  // All four pins pass two flops; select resets high so no false edge follows reset.
  pin_sync #(.WIDTH(4), .RST_VAL(4'h1)) u_pin_sync (
    .clk(core_clk),
    .rst(rst),
    .d({mod_in, sdata, sclk, cs_n}),
    .q(pins_s)
  );

  assign {mod_in_s, sdata_s, sclk_s, cs_n_s} = pins_s;

  // Edge memory for the synchronized clock and select.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_prev_ff <= 1'b0;
      cs_n_prev_ff <= 1'b1;
    end else begin
      sclk_prev_ff <= sclk_s;
      cs_n_prev_ff <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_ff;
  assign cs_start = ~cs_n_s & cs_n_prev_ff;
  assign cs_end = cs_n_s & ~cs_n_prev_ff;

  // Transfer framing: a transfer runs from select low to select high.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= SER_IDLE;
    end else begin
      unique case (state_ff)
        SER_IDLE: begin
          if (cs_start) begin
            state_ff <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          if (cs_end) begin
            state_ff <= SER_IDLE;
          end
        end
      endcase
    end
  end

  // Both data lines shift MSB first; the count saturates on long transfers.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_ff <= '0;
      mod_shift_ff <= '0;
      cnt_ff <= '0;
    end else if (cs_start) begin
      cnt_ff <= '0;
    end else if (state_ff == SER_SHIFT && sclk_rise && !cs_n_s) begin
      shift_ff <= {shift_ff[WORD_W-2:0], sdata_s};
      mod_shift_ff <= {mod_shift_ff[DATA_W-2:0], mod_in_s};
      if (cnt_ff != CNT_MAX) begin
        cnt_ff <= cnt_ff + 5'h01;
      end
    end
  end

  // Length decode at the end of a transfer.
  assign end_ev = (state_ff == SER_SHIFT) && cs_end;
  assign is_full = cnt_ff >= FULL_LEN;
  assign is_short = (cnt_ff >= SHORT_MIN) && (cnt_ff <= SHORT_MAX);
  assign wr_en = end_ev && is_full;
  assign wr_addr = shift_ff[WORD_W-1:DATA_W];
  assign wr_data = shift_ff[DATA_W-1:0];
  assign short_ld = end_ev && is_short && mod_ctl_ff[MOD_ADDR_DIS_BIT];
  assign short_sample = sext_sample(mod_ctl_ff[MOD_PIN_SEL_BIT] ? mod_shift_ff : shift_ff[DATA_W-1:0],
                                    cnt_ff);

  // Addressed register writes; unused addresses are ignored.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_div_ff <= RST_INT_DIV;
      frac_hi_ff <= RST_ZERO;
      frac_lo_ff <= RST_ZERO;
      ref_div_ff <= RST_ZERO;
      pump_ff <= RST_ZERO;
      pd_mux_ff <= RST_ZERO;
      mod_ctl_ff <= RST_ZERO;
      dsm_ff <= RST_ZERO;
    end else if (wr_en) begin
      unique case (wr_addr)
        ADDR_INT_DIV: int_div_ff <= wr_data;
        ADDR_FRAC_HI: frac_hi_ff <= wr_data;
        ADDR_FRAC_LO: frac_lo_ff <= wr_data;
        ADDR_REF_DIV: ref_div_ff <= wr_data;
        ADDR_PUMP: pump_ff <= wr_data;
        ADDR_PD_MUX: pd_mux_ff <= wr_data;
        ADDR_MOD_CTL: mod_ctl_ff <= wr_data;
        ADDR_DSM: dsm_ff <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // Modulation sample: addressed write or short addressless transfer.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mod_smp_ff <= RST_ZERO;
      mod_load_ff <= 1'b0;
    end else begin
      mod_load_ff <= short_ld || (wr_en && wr_addr == ADDR_MOD_SMP);
      if (wr_en && wr_addr == ADDR_MOD_SMP) begin
        mod_smp_ff <= wr_data;
      end else if (short_ld) begin
        mod_smp_ff <= short_sample;
      end
    end
  end

  // Divide ratio takes effect per mode; the host keeps the index in range.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_applied_ff <= RST_INT_DIV[DIV_IDX_W-1:0];
      frac_applied_ff <= '0;
      update_ff <= 1'b0;
    end else begin
      update_ff <= 1'b0;
      if (pd_mux_ff[PDM_INT_MODE_BIT]) begin
        if (wr_en && wr_addr == ADDR_INT_DIV) begin
          div_applied_ff <= wr_data[DIV_IDX_W-1:0];
          update_ff <= 1'b1;
        end
      end else if (wr_en && wr_addr == ADDR_FRAC_HI) begin
        div_applied_ff <= int_div_ff[DIV_IDX_W-1:0];
        update_ff <= 1'b1;
        if (pd_mux_ff[PDM_FRAC10_BIT]) begin
          frac_applied_ff <= {{FRAC_LO_W{1'b0}}, wr_data[FRAC_HI_W-1:0]};
        end else begin
          frac_applied_ff <= {wr_data[FRAC_HI_W-1:0], frac_lo_ff[FRAC_LO_W-1:0]};
        end
      end
    end
  end

  // Reference divide ratio is the index plus one.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_ratio_ff <= 6'h01;
    end else begin
      ref_ratio_ff <= {1'b0, ref_div_ff[REF_IDX_W-1:0]} + 6'h01;
    end
  end

  // Staging toward the modulation unit; a load while busy is sent later.
  assign busy = req_tgl_ff ^ ack_s;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_tgl_ff <= 1'b0;
      pend_ff <= 1'b0;
      stage_ff <= '0;
      stage_m_ff <= '0;
    end else if ((mod_load_ff || pend_ff) && !busy) begin
      stage_ff <= mod_smp_ff;
      stage_m_ff <= mod_ctl_ff[MOD_M_LSB +: MOD_M_W];
      req_tgl_ff <= ~req_tgl_ff;
      pend_ff <= 1'b0;
    end else if (mod_load_ff) begin
      pend_ff <= 1'b1;
    end
  end

  pin_sync #(.WIDTH(1)) u_ack_sync (
    .clk(core_clk),
    .rst(rst),
    .d(ack_tgl),
    .q(ack_s)
  );

  mod_handoff u_mod_handoff (
    .phase_detector_clock(phase_detector_clock),
    .rst(rst),
    .stage_sample(stage_ff),
    .stage_shift(stage_m_ff),
    .req_tgl(req_tgl_ff),
    .ack_tgl(ack_tgl),
    .mod_word(mod_word),
    .mod_word_valid(mod_word_valid)
  );

  // Outputs, all from flip-flops.
  assign divider_index = div_applied_ff;
  assign dividend = frac_applied_ff;
  assign ratio_update = update_ff;
  assign integer_mode = pd_mux_ff[PDM_INT_MODE_BIT];
  assign fraction_10bit = pd_mux_ff[PDM_FRAC10_BIT];
  assign ref_divide_ratio = ref_ratio_ff;
  assign pump_gain_control = pump_ff;
  assign powerdown_output_select = pd_mux_ff;
  assign modulator_control = dsm_ff;

  property p_reset_divider;
    @(posedge core_clk) rst |=> int_div_ff == RST_INT_DIV && divider_index == 9'h006;
  endproperty
  a_reset_divider: assert property (p_reset_divider) else $error("divider reset value wrong");
  property p_int_apply;
    @(posedge core_clk) disable iff (rst)
      wr_en && wr_addr == ADDR_INT_DIV && integer_mode
      |=> ratio_update && divider_index == $past(wr_data[DIV_IDX_W-1:0]);
  endproperty
  a_int_apply: assert property (p_int_apply) else $error("integer ratio not applied");
  property p_apply_cause;
    @(posedge core_clk) disable iff (rst)
      ratio_update |-> $past(wr_en) &&
        ($past(wr_addr) == (($past(integer_mode)) ? ADDR_INT_DIV : ADDR_FRAC_HI));
  endproperty
  a_apply_cause: assert property (p_apply_cause) else $error("ratio applied without cause");
  property p_frac18;
    @(posedge core_clk) disable iff (rst)
      wr_en && wr_addr == ADDR_FRAC_HI && !integer_mode && !fraction_10bit
      |=> dividend == {$past(wr_data[FRAC_HI_W-1:0]), $past(frac_lo_ff[FRAC_LO_W-1:0])};
  endproperty
  a_frac18: assert property (p_frac18) else $error("18-bit dividend wrong");
  property p_frac10;
    @(posedge core_clk) disable iff (rst)
      wr_en && wr_addr == ADDR_FRAC_HI && !integer_mode && fraction_10bit
      |=> dividend == {8'h00, $past(wr_data[FRAC_HI_W-1:0])};
  endproperty
  a_frac10: assert property (p_frac10) else $error("10-bit dividend wrong");
  property p_discard;
    @(posedge core_clk) disable iff (rst)
      end_ev && (cnt_ff == 5'h01 || (cnt_ff > SHORT_MAX && cnt_ff < FULL_LEN))
      |=> !mod_load_ff && $stable(int_div_ff) && $stable(mod_ctl_ff);
  endproperty
  a_discard: assert property (p_discard) else $error("illegal length changed state");
  property p_short_load;
    @(posedge core_clk) disable iff (rst)
      short_ld |=> mod_load_ff && mod_smp_ff == $past(short_sample);
  endproperty
  a_short_load: assert property (p_short_load) else $error("short sample not loaded");
  property p_mod_write;
    @(posedge core_clk) disable iff (rst)
      wr_en && wr_addr == ADDR_MOD_SMP |=> mod_load_ff && mod_smp_ff == $past(wr_data);
  endproperty
  a_mod_write: assert property (p_mod_write) else $error("addressed sample not loaded");
  property p_shift_count;
    @(posedge core_clk) disable iff (rst)
      state_ff == SER_SHIFT && sclk_rise && !cs_n_s && !cs_start && cnt_ff != CNT_MAX
      |=> cnt_ff == $past(cnt_ff) + 5'h01 && shift_ff[0] == $past(sdata_s);
  endproperty
  a_shift_count: assert property (p_shift_count) else $error("serial bit not shifted");
  property p_ref_ratio;
    @(posedge core_clk) disable iff (rst)
      1'b1 |=> ref_divide_ratio == {1'b0, $past(ref_div_ff[REF_IDX_W-1:0])} + 6'h01;
  endproperty
  a_ref_ratio: assert property (p_ref_ratio) else $error("reference ratio wrong");

  c_full_write: cover property (@(posedge core_clk) disable iff (rst) end_ev && cnt_ff == FULL_LEN);
  c_long_write: cover property (@(posedge core_clk) disable iff (rst) end_ev && cnt_ff > FULL_LEN);
  c_short_pin: cover property (@(posedge core_clk) disable iff (rst)
    short_ld && mod_ctl_ff[MOD_PIN_SEL_BIT]);
  c_pending: cover property (@(posedge core_clk) disable iff (rst) mod_load_ff && busy);

endmodule

// ==== verification/host_serial_model.sv ====
/*
  Behavioural host on the three-wire serial link, sending frames of up to 32 bits
  MSB first on the data pin or on the alternate modulation pin.
  Assumes the caller never starts a frame while another is running.
*/
`timescale 1ns/1ns
module host_serial_model (
  // Serial pins toward the device.
  output logic sclk,
  output logic sdata,
  output logic cs_n,
  output logic mod_in
);
  // Idle link: clock parked low, device deselected.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdata = 1'b0;
    mod_in = 1'b1;
  end

  // Sends the low n bits of val; the unused data line carries junk.
  task automatic send(input int n, input logic [31:0] val, input logic alt);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      if (alt) begin
        mod_in = val[i];
        sdata = ~sdata;
      end else begin
        sdata = val[i];
        mod_in = ~mod_in;
      end
      #62 sclk = 1'b1;
      #63 sclk = 1'b0;
    end
    #62 cs_n = 1'b1;
    // Released lines must not keep showing the last bit.
    sdata = ~sdata;
    mod_in = ~mod_in;
    #250;
  endtask
endmodule

// ==== verification/synth_serial_register_bank_tb.sv ====
/*
  Self-checking bench of the synthesizer register bank: the host model
  drives frames, queues of expected ratio updates and samples are checked.
  Assumes the host model and the design are compiled first.
*/
`timescale 1ns/1ns
module synth_serial_register_bank_tb
  import synth_pkg::*;
();
  logic core_clk, rst, phase_detector_clock, sclk, sdata, cs_n, mod_in;
  logic [DIV_IDX_W-1:0] divider_index;
  logic [FRAC_W-1:0] dividend;
  logic ratio_update, integer_mode, fraction_10bit, mod_word_valid;
  logic [REF_IDX_W:0] ref_divide_ratio;
  logic [DATA_W-1:0] pump_gain_control, powerdown_output_select, modulator_control;
  logic [MOD_OUT_W-1:0] mod_word;
  logic [31:0] ratio_q[$];
  logic [31:0] mod_q[$];
  int fail_count = 0;
  int total_checks = 0;

  // Core clock at 4 ns and phase detector clock at 10 ns.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    phase_detector_clock = 1'b0;
    forever #5 phase_detector_clock = ~phase_detector_clock;
  end

  synth_serial_register_bank synth_serial_register_bank_i (
    .core_clk(core_clk), .rst(rst), .phase_detector_clock(phase_detector_clock),
    .sclk(sclk), .sdata(sdata), .cs_n(cs_n), .mod_in(mod_in),
    .divider_index(divider_index), .dividend(dividend), .ratio_update(ratio_update),
    .integer_mode(integer_mode), .fraction_10bit(fraction_10bit),
    .ref_divide_ratio(ref_divide_ratio), .pump_gain_control(pump_gain_control),
    .powerdown_output_select(powerdown_output_select),
    .modulator_control(modulator_control), .mod_word(mod_word),
    .mod_word_valid(mod_word_valid));
  host_serial_model host_serial_model_i (.sclk(sclk), .sdata(sdata), .cs_n(cs_n),
    .mod_in(mod_in));

  // Counts a comparison and reports a difference at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Sends one addressed 16-bit register write.
  task automatic wr(input logic [3:0] addr, input logic [11:0] data);
    host_serial_model_i.send(16, {16'h0000, addr, data}, 1'b0);
  endtask

  // Expected modulation word: n-bit sample sign-extended, shifted by m.
  function automatic logic [31:0] scaled(input logic [11:0] v, input int n, input int m);
    logic [11:0] s;
    logic [26:0] w;
    s = v << (12 - n);
    s = $signed(s) >>> (12 - n);
    w = {{15{s[11]}}, s};
    return {5'h00, w << m};
  endfunction

  // Ratio updates are sampled mid-cycle, away from the launching edge.
  always @(negedge core_clk) begin
    if (ratio_update === 1'b1) begin
      if (ratio_q.size() == 0) begin
        check("unexpected ratio", 32'h1, 32'h0);
      end else begin
        check("ratio", {5'h00, divider_index, dividend}, ratio_q.pop_front());
      end
    end
  end

  // A sample pulse spans one phase detector period, so one rising edge.
  always @(posedge phase_detector_clock) begin
    if (mod_word_valid === 1'b1) begin
      if (mod_q.size() == 0) begin
        check("unexpected sample", 32'h1, 32'h0);
      end else begin
        check("mod_word", {5'h00, mod_word}, mod_q.pop_front());
      end
    end
  end

  // Main sequence: reset, ratio modes, plain registers, samples.
  initial begin
    logic [11:0] d, lo, hi, v;
    int m, n;
    rst = 1'b1;
    void'($urandom(92));
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check("divider_index", divider_index, 32'h6);
    check("dividend", dividend, 32'h0);
    check("ref ratio", ref_divide_ratio, 32'h1);
    check("pump", pump_gain_control, 32'h0);
    check("modulator", modulator_control, 32'h0);
    wr(4'h7, 12'h004);
    check("pd_mux", powerdown_output_select, 32'h004);
    check("integer_mode", integer_mode, 32'h1);
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 12'h000 : (i == 1) ? 12'h1FF : 12'($urandom_range(511));
      ratio_q.push_back({5'h00, d[8:0], 18'h00000});
      wr(4'h0, d);
    end
    wr(4'h1, 12'h155);
    wr(4'h7, 12'h000);
    d = 12'($urandom_range(505, 6));
    lo = 12'($urandom);
    hi = 12'($urandom);
    wr(4'h0, d);
    wr(4'h2, lo);
    ratio_q.push_back({5'h00, d[8:0], hi[9:0], lo[7:0]});
    wr(4'h1, hi);
    wr(4'h7, 12'h008);
    check("fraction_10bit", fraction_10bit, 32'h1);
    wr(4'h0, d);
    wr(4'h2, ~lo);
    ratio_q.push_back({5'h00, d[8:0], 8'h00, hi[9:0]});
    wr(4'h1, hi);
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(30, 1);
      wr(4'h5, 12'(n));
      check("ref ratio", ref_divide_ratio, 32'(n + 1));
    end
    d = 12'($urandom);
    host_serial_model_i.send(20, {12'h000, 4'hA, 4'h6, d}, 1'b0);
    check("pump", pump_gain_control, 32'(d));
    foreach (lo[i]) begin
      if (i < 4) begin
        host_serial_model_i.send((i == 0) ? 1 : 12 + i, {16'h0000, 4'h6, ~d}, 1'b0);
      end
    end
    wr(4'h3, ~d);
    check("pump", pump_gain_control, 32'(d));
    wr(4'hE, ~d);
    check("modulator", modulator_control, {20'h00000, ~d});
    // Short addressless samples, first on the data pin, then on the modulation pin.
    for (int alt = 0; alt < 2; alt++) begin
      // The first pass keeps the shift m at 3 or less; the second allows up to 13.
      m = (alt == 0) ? $urandom_range(3) : $urandom_range(13);
      wr(4'h8, 12'(alt * 32 + 16 + m));
      for (int k = 0; k < 3; k++) begin
        n = (k == 0) ? 2 : (k == 1) ? 12 : $urandom_range(11, 3);
        v = 12'($urandom);
        mod_q.push_back(scaled(v, n, m));
        host_serial_model_i.send(n, {20'h00000, v}, alt[0]);
      end
    end
    wr(4'h8, 12'(m));
    host_serial_model_i.send(6, 32'h2A, 1'b0);
    v = 12'($urandom);
    mod_q.push_back(scaled(v, 12, m));
    wr(4'h9, v);
    for (int t = 0; t < 1000 && (ratio_q.size() + mod_q.size()) > 0; t++) begin
      @(negedge core_clk);
    end
    check("pending", 32'(ratio_q.size() + mod_q.size()), 32'h0);
    wrap_up();
  end
endmodule
